/* File: dgpb_regs.svh */
// Purpose: Offsets, field positions and reset values of the GPIO bank
// Assumes: Byte-wide registers on a 3-bit register address
// Notes: Included by bare name from the design files
`ifndef DGPB_REGS_SVH
`define DGPB_REGS_SVH

// Register offsets
`define DGPB_OFF_P7_LATCH 3'h0
`define DGPB_OFF_P7_DIR 3'h1
`define DGPB_OFF_P7_PULLUP 3'h2
`define DGPB_OFF_PF_LATCH 3'h3
`define DGPB_OFF_PF_DIR 3'h4
`define DGPB_OFF_CTRL 3'h5
`define DGPB_OFF_WAKE 3'h6

// Control register fields
`define DGPB_CTRL_FLOAT_BIT 0
`define DGPB_CTRL_XRST_BIT 1
`define DGPB_CTRL_MASK 8'h03

// Wake keep-input enable fields
`define DGPB_WAKE_TIMER_BIT 0
`define DGPB_WAKE_SCLK_BIT 1
`define DGPB_WAKE_SDIN_BIT 2
`define DGPB_WAKE_MASK 8'h07

// Pin positions of special functions
`define DGPB_P7_TIMER_PIN 4
`define DGPB_P7_SCLK_PIN 5
`define DGPB_P7_SDIN_PIN 7
`define DGPB_PF_RESET_PIN 2

// Implemented bits
`define DGPB_P7_PULLUP_MASK 8'hf3
`define DGPB_PF_MASK 8'h07

// Reset values
`define DGPB_RST_LATCH 8'h00
`define DGPB_RST_DIR 8'h00
`define DGPB_RST_PULLUP 8'h00
`define DGPB_RST_CTRL 8'h02
`define DGPB_RST_WAKE 8'h00

`endif

/* File: dgpb_pkg.sv */
// Purpose: Shared types of the GPIO bank
// Assumes: Constants live in dgpb_regs.svh
// Notes: Types only
package dgpb_pkg;
   typedef logic [7:0] dgpb_byte_t;
   typedef logic [2:0] dgpb_addr_t;
   typedef logic [2:0] dgpb_fbits_t;
endpackage

/* File: dgpb_pin_cell.sv */
// Purpose: Drive, release, pull-up and input gating of one port pin
// Assumes: All inputs come from the ref_clk domain or from synchronised pins
// Notes: Purely combinational
`timescale 1ns/100ps
module dgpb_pin_cell
   import dgpb_pkg::*;
(
   // Configuration
   input wire logic dir,
   input wire logic latch,
   input wire logic open_drain,
   input wire logic pullup_en,
   // Peripheral sharing
   input wire logic periph_oe,
   input wire logic periph_out,
   // Standby
   input wire logic float_en,
   input wire logic keep_input,
   // Pin side
   input wire logic pin_level,
   output logic pin_o,
   output logic pin_oe_n,
   output logic pullup_on,
   output logic in_path
);
   logic drive;
   logic val;

   always_comb begin
      val = periph_oe ? periph_out : latch;
      drive = ~float_en & (periph_oe | dir);
      pin_o = val;
      pin_oe_n = ~(drive & ~(open_drain & val));
      pullup_on = pullup_en & ~(~pin_oe_n & ~val);
      in_path = (float_en & ~keep_input) ? 1'b0 : pin_level;
   end
endmodule

/* File: dgpb_port_bank.sv */
// Purpose: Eight-bit port 7 and three-bit port F with register access
// Assumes: Pin inputs are asynchronous; strobes and standby come from ref_clk logic
// Notes: Read data stand one cycle after the read strobe only
// Behaviour
// - Direction bit one makes the pin a port-driven output.
// - Direction bit zero releases the driver unless a peripheral output is enabled; the pin is then an input.
// - An output pin drives its latch bit.
// - Data writes update the latch and output pins show it at once.
// - Data writes on input pins update the latch without driving.
// - Ordinary reads return the latch for port output pins.
// - Ordinary reads return the sampled pin level for input pins.
// - Read-modify-write reads return the latch whatever the pin setup, except the port F pin used as external reset, which reads zero.
// - An enabled peripheral output drives the pin instead of the latch.
// - With peripheral output enabled, ordinary reads return the real pin level.
// - Reset clears all direction bits so every pin is an input.
// - Float bit one in stop or watch releases every pin.
// - Floated pins block their input path; those set as inputs read low.
// - Timer clock, serial clock, serial data pins stay open when wake-enabled.
// - Float bit zero in standby keeps pin states and output levels.
// - Pull-up bit one connects the pull-up; zero leaves it off.
// - A pin driven low always disconnects its pull-up.
// - Open-drain output with latch one stays released.
// - Port 7 register bit n maps to pin n in all registers.
// - Port F bits 0 to 2 map to its pins; upper bits unused.
// - External reset selected means the shared pin is no port pin.
`timescale 1ns/100ps
`include "dgpb_regs.svh"
module dgpb_port_bank
   import dgpb_pkg::*;
#(
   parameter dgpb_byte_t P7_OPEN_DRAIN = 8'h00,
   parameter dgpb_fbits_t PF_OPEN_DRAIN = 3'h0
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rmw,
   output logic [7:0] reg_rdata,
   // Standby
   input wire logic standby_active,
   // Peripheral sharing on port 7
   input wire logic [7:0] p7_periph_oe,
   input wire logic [7:0] p7_periph_out,
   output logic [7:0] p7_periph_in,
   // Port 7 pins
   input wire logic [7:0] p7_pin_i,
   output logic [7:0] p7_pin_o,
   output logic [7:0] p7_pin_oe_n,
   output logic [7:0] p7_pullup_on,
   // Port F pins
   input wire logic [2:0] pf_pin_i,
   output logic [2:0] pf_pin_o,
   output logic [2:0] pf_pin_oe_n,
   output logic [2:0] pf_periph_in,
   output logic external_reset_select
);
   dgpb_byte_t p7_latch_q, p7_latch_d;
   dgpb_byte_t p7_dir_q, p7_dir_d;
   dgpb_byte_t p7_pullup_q, p7_pullup_d;
   dgpb_fbits_t pf_latch_q, pf_latch_d;
   dgpb_fbits_t pf_dir_q, pf_dir_d;
   dgpb_byte_t ctrl_q, ctrl_d;
   dgpb_byte_t wake_q, wake_d;
   dgpb_byte_t rdata_q, rdata_d;
   dgpb_byte_t p7_meta_q, p7_meta_d;
   dgpb_byte_t p7_sync_q, p7_sync_d;
   dgpb_fbits_t pf_meta_q, pf_meta_d;
   dgpb_fbits_t pf_sync_q, pf_sync_d;
   logic stby_float;
   dgpb_byte_t p7_keep;
   dgpb_byte_t p7_in_path;
   dgpb_fbits_t pf_in_path;
   dgpb_fbits_t pf_dir_eff;
   dgpb_byte_t p7_rd_val;
   dgpb_byte_t pf_rd_val;

   // Readback mux shared by both ports
   function automatic dgpb_byte_t read_mux(input dgpb_byte_t latch, input dgpb_byte_t dir,
                                           input dgpb_byte_t poe, input dgpb_byte_t pin,
                                           input logic rmw);
      dgpb_byte_t port_out;
      port_out = dir & ~poe;
      if (rmw) begin
         read_mux = latch;
      end else begin
         read_mux = (latch & port_out) | (pin & ~port_out);
      end
   endfunction

   // Floating applies only when both standby and the float bit hold;
   // otherwise standby leaves every pin exactly as configured.
   // float qualifier
   assign stby_float = standby_active & ctrl_q[`DGPB_CTRL_FLOAT_BIT];
   assign external_reset_select = ctrl_q[`DGPB_CTRL_XRST_BIT];

   always_comb begin
      p7_keep = 8'h00;
      p7_keep[`DGPB_P7_TIMER_PIN] = wake_q[`DGPB_WAKE_TIMER_BIT];
      p7_keep[`DGPB_P7_SCLK_PIN] = wake_q[`DGPB_WAKE_SCLK_BIT];
      p7_keep[`DGPB_P7_SDIN_PIN] = wake_q[`DGPB_WAKE_SDIN_BIT];
   end

   for (genvar i = 0; i < 8; i++) begin : g_p7
      dgpb_pin_cell u_cell (
         .dir(p7_dir_q[i]),
         .latch(p7_latch_q[i]),
         .open_drain(P7_OPEN_DRAIN[i]),
         .pullup_en(p7_pullup_q[i]),
         .periph_oe(p7_periph_oe[i]),
         .periph_out(p7_periph_out[i]),
         .float_en(stby_float),
         .keep_input(p7_keep[i]),
         .pin_level(p7_sync_q[i]),
         .pin_o(p7_pin_o[i]),
         .pin_oe_n(p7_pin_oe_n[i]),
         .pullup_on(p7_pullup_on[i]),
         .in_path(p7_in_path[i])
      );
   end

   always_comb begin
      pf_dir_eff = pf_dir_q;
      if (external_reset_select) begin
         pf_dir_eff[`DGPB_PF_RESET_PIN] = 1'b0;
      end
   end

   for (genvar j = 0; j < 3; j++) begin : g_pf
      dgpb_pin_cell u_cell (
         .dir(pf_dir_eff[j]),
         .latch(pf_latch_q[j]),
         .open_drain(PF_OPEN_DRAIN[j]),
         .pullup_en(1'b0),
         .periph_oe(1'b0),
         .periph_out(1'b0),
         .float_en(stby_float),
         .keep_input(1'b0),
         .pin_level(pf_sync_q[j]),
         .pin_o(pf_pin_o[j]),
         .pin_oe_n(pf_pin_oe_n[j]),
         .pullup_on(),
         .in_path(pf_in_path[j])
      );
   end

   assign p7_periph_in = p7_in_path;
   assign pf_periph_in = pf_in_path;

   always_comb begin
      p7_rd_val = read_mux(p7_latch_q, p7_dir_q, p7_periph_oe, p7_in_path, reg_rmw);
      pf_rd_val = read_mux({5'h00, pf_latch_q}, {5'h00, pf_dir_eff}, 8'h00,
                           {5'h00, pf_in_path}, reg_rmw) & `DGPB_PF_MASK;
      if (external_reset_select) begin
         pf_rd_val[`DGPB_PF_RESET_PIN] = 1'b0;
      end
   end

   // Register and synchroniser next values; clk_en low freezes everything
   always_comb begin
      p7_latch_d = p7_latch_q;
      p7_dir_d = p7_dir_q;
      p7_pullup_d = p7_pullup_q;
      pf_latch_d = pf_latch_q;
      pf_dir_d = pf_dir_q;
      ctrl_d = ctrl_q;
      wake_d = wake_q;
      rdata_d = rdata_q;
      p7_meta_d = p7_meta_q;
      p7_sync_d = p7_sync_q;
      pf_meta_d = pf_meta_q;
      pf_sync_d = pf_sync_q;
      if (clk_en) begin
         p7_meta_d = p7_pin_i;
         p7_sync_d = p7_meta_q;
         pf_meta_d = pf_pin_i;
         pf_sync_d = pf_meta_q;
         rdata_d = 8'h00;
         if (reg_wr) begin
            unique case (reg_addr)
               `DGPB_OFF_P7_LATCH: p7_latch_d = reg_wdata;
               `DGPB_OFF_P7_DIR: p7_dir_d = reg_wdata;
               `DGPB_OFF_P7_PULLUP: p7_pullup_d = reg_wdata & `DGPB_P7_PULLUP_MASK;
               `DGPB_OFF_PF_LATCH: pf_latch_d = reg_wdata[2:0];
               `DGPB_OFF_PF_DIR: pf_dir_d = reg_wdata[2:0];
               `DGPB_OFF_CTRL: ctrl_d = reg_wdata & `DGPB_CTRL_MASK;
               `DGPB_OFF_WAKE: wake_d = reg_wdata & `DGPB_WAKE_MASK;
               default: ;
            endcase
         end
         if (reg_rd) begin
            unique case (reg_addr)
               `DGPB_OFF_P7_LATCH: rdata_d = p7_rd_val;
               `DGPB_OFF_P7_DIR: rdata_d = p7_dir_q;
               `DGPB_OFF_P7_PULLUP: rdata_d = p7_pullup_q;
               `DGPB_OFF_PF_LATCH: rdata_d = pf_rd_val;
               `DGPB_OFF_PF_DIR: rdata_d = {5'h00, pf_dir_q};
               `DGPB_OFF_CTRL: rdata_d = ctrl_q;
               `DGPB_OFF_WAKE: rdata_d = wake_q;
               // Unmapped offsets read zero
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         p7_latch_q <= `DGPB_RST_LATCH;
         p7_dir_q <= `DGPB_RST_DIR;
         p7_pullup_q <= `DGPB_RST_PULLUP;
         pf_latch_q <= 3'h0;
         pf_dir_q <= 3'h0;
         ctrl_q <= `DGPB_RST_CTRL;
         wake_q <= `DGPB_RST_WAKE;
         rdata_q <= 8'h00;
         p7_meta_q <= 8'h00;
         p7_sync_q <= 8'h00;
         pf_meta_q <= 3'h0;
         pf_sync_q <= 3'h0;
      end else begin
         p7_latch_q <= p7_latch_d;
         p7_dir_q <= p7_dir_d;
         p7_pullup_q <= p7_pullup_d;
         pf_latch_q <= pf_latch_d;
         pf_dir_q <= pf_dir_d;
         ctrl_q <= ctrl_d;
         wake_q <= wake_d;
         rdata_q <= rdata_d;
         p7_meta_q <= p7_meta_d;
         p7_sync_q <= p7_sync_d;
         pf_meta_q <= pf_meta_d;
         pf_sync_q <= pf_sync_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Checks on the driven side
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_latch_write;
      clk_en && reg_wr && reg_addr == `DGPB_OFF_P7_LATCH;
   endsequence

   sequence s_plain_read;
      clk_en && reg_rd && !reg_rmw && reg_addr == `DGPB_OFF_P7_LATCH;
   endsequence

   sequence s_rmw_read;
      clk_en && reg_rd && reg_rmw && reg_addr == `DGPB_OFF_P7_LATCH;
   endsequence

   AST_DIR_RESET: assert property ($rose(rst_n) |-> p7_dir_q == 8'h00 && pf_dir_q == 3'h0)
      else $error("direction not cleared by reset");

   AST_PORT_DRIVES: assert property (!stby_float |->
      ((~p7_pin_oe_n | ~p7_dir_q | p7_periph_oe | P7_OPEN_DRAIN) == 8'hff))
      else $error("output pin not driven");

   AST_INPUT_RELEASED: assert property (!stby_float |->
      ((p7_pin_oe_n | p7_dir_q | p7_periph_oe) == 8'hff))
      else $error("input pin driven");

   AST_LATCH_ON_PIN: assert property (
      ((p7_pin_o ^ p7_latch_q) & ~p7_pin_oe_n & ~p7_periph_oe) == 8'h00)
      else $error("output pin differs from latch");

   AST_WRITE_SHOWS: assert property (s_latch_write |=>
      p7_latch_q == $past(reg_wdata) && ((p7_pin_o ^ p7_latch_q) & ~p7_periph_oe) == 8'h00)
      else $error("latch write not applied");

   AST_INPUT_WRITE: assert property (s_latch_write |=>
      (~p7_pin_oe_n & ~p7_dir_q & ~p7_periph_oe) == 8'h00)
      else $error("latch write drove an input pin");

   AST_RMW_READ: assert property (s_rmw_read |=> reg_rdata == $past(p7_latch_q))
      else $error("read-modify-write read not latch");

   AST_PLAIN_READ: assert property (s_plain_read |=>
      reg_rdata == (($past(p7_latch_q) & $past(p7_dir_q) & ~$past(p7_periph_oe)) |
                    ($past(p7_in_path) & ~($past(p7_dir_q) & ~$past(p7_periph_oe)))))
      else $error("plain read wrong source");

   AST_PERIPH_READ: assert property (s_plain_read |=>
      ((reg_rdata ^ $past(p7_in_path)) & $past(p7_periph_oe)) == 8'h00)
      else $error("peripheral output not read back from pin");

   AST_READ_ONE_CYCLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data held too long");

   AST_PERIPH_DRIVES: assert property (!stby_float |->
      ((p7_pin_oe_n & p7_periph_oe & ~P7_OPEN_DRAIN) == 8'h00) &&
      (((p7_pin_o ^ p7_periph_out) & p7_periph_oe) == 8'h00))
      else $error("peripheral output not on pin");

   AST_FLOAT_RELEASE: assert property (stby_float |->
      p7_pin_oe_n == 8'hff && pf_pin_oe_n == 3'h7)
      else $error("pin driven while floated");

   AST_FLOAT_BLOCK: assert property (stby_float |->
      (p7_periph_in & ~p7_keep) == 8'h00 && pf_periph_in == 3'h0)
      else $error("floated input not blocked");

   AST_WAKE_KEEP: assert property (stby_float |->
      ((p7_periph_in ^ p7_sync_q) & p7_keep) == 8'h00)
      else $error("wake input blocked");

   AST_HOLD: assert property (standby_active && !ctrl_q[`DGPB_CTRL_FLOAT_BIT] |->
      p7_periph_in == p7_sync_q &&
      ((~p7_pin_oe_n ^ (p7_dir_q | p7_periph_oe)) & ~P7_OPEN_DRAIN) == 8'h00)
      else $error("standby without float changed pins");

   AST_PULLUP_ON: assert property (
      (p7_pullup_on ^ (p7_pullup_q & (p7_pin_oe_n | p7_pin_o))) == 8'h00)
      else $error("pull-up not as programmed");

   AST_PULLUP_LOW: assert property (((p7_pullup_on & ~p7_pin_oe_n & ~p7_pin_o) == 8'h00)
      && ((p7_pullup_on & ~p7_pullup_q) == 8'h00))
      else $error("pull-up on a low driven pin");

   AST_OPEN_DRAIN: assert property (
      (~p7_pin_oe_n & P7_OPEN_DRAIN & p7_pin_o) == 8'h00)
      else $error("open-drain pin driven high");

   AST_PF_DRIVES: assert property (!stby_float |->
      pf_pin_o == pf_latch_q && pf_pin_oe_n == ~(pf_dir_eff & ~(PF_OPEN_DRAIN & pf_latch_q)))
      else $error("port F pin not as programmed");

   AST_PULLUP_GAP: assert property (
      clk_en && reg_wr && reg_addr == `DGPB_OFF_P7_PULLUP |=> p7_pullup_q[3:2] == 2'h0)
      else $error("missing pull-up bit stored");

   AST_RESET_PIN: assert property (external_reset_select |->
      pf_pin_oe_n[`DGPB_PF_RESET_PIN] && !pf_rd_val[`DGPB_PF_RESET_PIN])
      else $error("reset pin used as port pin");
endmodule

/* File: dgpb_board_model.sv */
// Purpose: Board circuitry on the port pins, resolving each pin's level
// Assumes: Device drive wins over the board; board drives only released pins
// Notes: A released, unpulled pin toggles every cycle so stale values never match
`timescale 1ns/100ps
module dgpb_board_model
   import dgpb_pkg::*;
#(
   parameter int W = 8
)
(
   // Clock
   input wire logic ref_clk,
   // Device side
   input wire logic [W-1:0] pin_o,
   input wire logic [W-1:0] pin_oe_n,
   input wire logic [W-1:0] pullup_on,
   // Board side
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] level
);
   logic [W-1:0] last_q = '0;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!pin_oe_n[i]) level[i] = pin_o[i];
         else if (ext_en[i]) level[i] = ext_val[i];
         else if (pullup_on[i]) level[i] = 1'b1;
         else level[i] = ~last_q[i];
      end
   end
   always_ff @(posedge ref_clk) last_q <= level;
endmodule

/* File: dual_gpio_port_bank_test.sv */
// Purpose: Register-level test of the two-port GPIO bank
// Assumes: Pin levels come from the board model; bit 7 of port 7 is open drain
// Notes: Pin changes need two cycles to pass the input synchronisers
`timescale 1ns/100ps
`include "dgpb_regs.svh"
module dual_gpio_port_bank_test
   import dgpb_pkg::*;
;
   logic ref_clk = 1'b0, rst_n, clk_en, reg_wr, reg_rd, reg_rmw, standby_active;
   logic external_reset_select;
   dgpb_addr_t reg_addr;
   dgpb_byte_t reg_wdata, reg_rdata, p7_periph_oe, p7_periph_out, p7_periph_in;
   dgpb_byte_t p7_pin_i, p7_pin_o, p7_pin_oe_n, p7_pullup_on, ext7_en, ext7_val;
   dgpb_fbits_t pf_pin_i, pf_pin_o, pf_pin_oe_n, pf_periph_in, extf_en, extf_val;
   int n_fail = 0;
   int checks = 0;

   always #5 ref_clk = ~ref_clk;

   dgpb_port_bank #(.P7_OPEN_DRAIN(8'h80), .PF_OPEN_DRAIN(3'h0)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
      .reg_rdata(reg_rdata), .standby_active(standby_active),
      .p7_periph_oe(p7_periph_oe), .p7_periph_out(p7_periph_out),
      .p7_periph_in(p7_periph_in), .p7_pin_i(p7_pin_i), .p7_pin_o(p7_pin_o),
      .p7_pin_oe_n(p7_pin_oe_n), .p7_pullup_on(p7_pullup_on), .pf_pin_i(pf_pin_i),
      .pf_pin_o(pf_pin_o), .pf_pin_oe_n(pf_pin_oe_n), .pf_periph_in(pf_periph_in),
      .external_reset_select(external_reset_select));

   dgpb_board_model i_board7 (.ref_clk(ref_clk), .pin_o(p7_pin_o),
      .pin_oe_n(p7_pin_oe_n), .pullup_on(p7_pullup_on), .ext_en(ext7_en),
      .ext_val(ext7_val), .level(p7_pin_i));
   dgpb_board_model #(.W(3)) i_boardf (.ref_clk(ref_clk), .pin_o(pf_pin_o),
      .pin_oe_n(pf_pin_oe_n), .pullup_on(3'h0), .ext_en(extf_en), .ext_val(extf_val),
      .level(pf_pin_i));

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input dgpb_byte_t exp, input dgpb_byte_t got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input dgpb_addr_t a, input dgpb_byte_t d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input dgpb_addr_t a, input logic rmw, input dgpb_byte_t exp,
                     input string what);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rmw <= rmw;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_rmw <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask

   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   initial begin
      #100us;
      n_fail++;
      final_report();
   end

   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_rmw = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      standby_active = 1'b0;
      p7_periph_oe = 8'h00;
      p7_periph_out = 8'h00;
      ext7_en = 8'hff;
      ext7_val = 8'h3c;
      extf_en = 3'h7;
      extf_val = 3'h5;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("p7 oe_n after reset", 8'hff, p7_pin_oe_n);
      chk("pf oe_n after reset", 8'h07, {5'h00, pf_pin_oe_n});
      rd(`DGPB_OFF_P7_DIR, 1'b0, 8'h00, "p7 direction reset");
      rd(`DGPB_OFF_PF_DIR, 1'b0, 8'h00, "pf direction reset");
      rd(`DGPB_OFF_P7_PULLUP, 1'b0, 8'h00, "p7 pull-up reset");
      rd(`DGPB_OFF_CTRL, 1'b0, 8'h02, "control reset");
      rd(`DGPB_OFF_PF_LATCH, 1'b0, 8'h01, "pf input read");
      rd(3'h7, 1'b0, 8'h00, "unmapped read");
      // Latch written while all pins are inputs
      wr(`DGPB_OFF_P7_LATCH, 8'ha5);
      chk("p7 oe_n input latch write", 8'hff, p7_pin_oe_n);
      wr(`DGPB_OFF_P7_DIR, 8'h0f);
      chk("p7 oe_n low nibble out", 8'hf0, p7_pin_oe_n);
      chk("p7 drive value", 8'h05, p7_pin_o & 8'h0f);
      settle();
      rd(`DGPB_OFF_P7_LATCH, 1'b0, 8'h35, "p7 plain read");
      rd(`DGPB_OFF_P7_LATCH, 1'b1, 8'ha5, "p7 rmw read");
      // Peripheral output on bit 0 overrides the latch
      @(posedge ref_clk);
      p7_periph_oe <= 8'h01;
      settle();
      chk("periph drives pin", 8'h00, p7_pin_o & 8'h01);
      chk("periph oe_n", 8'hf0, p7_pin_oe_n);
      rd(`DGPB_OFF_P7_LATCH, 1'b0, 8'h34, "periph loopback read");
      rd(`DGPB_OFF_P7_LATCH, 1'b1, 8'ha5, "periph rmw read");
      @(posedge ref_clk);
      p7_periph_oe <= 8'h00;
      // Pull-ups, with bits 1 and 3 driven low
      wr(`DGPB_OFF_P7_PULLUP, 8'hff);
      rd(`DGPB_OFF_P7_PULLUP, 1'b0, 8'hf3, "pull-up holes");
      chk("pull-up on", 8'hf1, p7_pullup_on);
      wr(`DGPB_OFF_P7_PULLUP, 8'h00);
      chk("pull-up off", 8'h00, p7_pullup_on);
      // Open-drain bit 7
      wr(`DGPB_OFF_P7_DIR, 8'h8f);
      chk("open drain high released", 8'hf0, p7_pin_oe_n);
      wr(`DGPB_OFF_P7_LATCH, 8'h25);
      chk("open drain low driven", 8'h70, p7_pin_oe_n);
      chk("open drain low value", 8'h00, p7_pin_o & 8'h80);
      wr(`DGPB_OFF_P7_DIR, 8'h0f);
      // Floated standby, timer clock pin kept
      wr(`DGPB_OFF_CTRL, 8'h01);
      wr(`DGPB_OFF_WAKE, 8'h01);
      @(posedge ref_clk);
      ext7_val <= 8'hff;
      standby_active <= 1'b1;
      settle();
      chk("float p7 oe_n", 8'hff, p7_pin_oe_n);
      chk("float pf oe_n", 8'h07, {5'h00, pf_pin_oe_n});
      chk("float input gating", 8'h10, p7_periph_in);
      wr(`DGPB_OFF_WAKE, 8'h07);
      chk("float wake inputs", 8'hb0, p7_periph_in);
      // Standby without float keeps outputs
      wr(`DGPB_OFF_CTRL, 8'h00);
      settle();
      chk("hold p7 oe_n", 8'hf0, p7_pin_oe_n);
      chk("hold p7 value", 8'h05, p7_pin_o & 8'h0f);
      chk("hold input path", 8'hf5, p7_periph_in);
      @(posedge ref_clk);
      standby_active <= 1'b0;
      // Port F with external reset off, then on
      wr(`DGPB_OFF_PF_LATCH, 8'hff);
      wr(`DGPB_OFF_PF_DIR, 8'h07);
      chk("pf drive value", 8'h07, {5'h00, pf_pin_o});
      chk("pf oe_n", 8'h00, {5'h00, pf_pin_oe_n});
      rd(`DGPB_OFF_PF_LATCH, 1'b1, 8'h07, "pf rmw unused bits");
      wr(`DGPB_OFF_PF_LATCH, 8'h06);
      settle();
      rd(`DGPB_OFF_PF_LATCH, 1'b0, 8'h06, "pf plain read");
      wr(`DGPB_OFF_CTRL, 8'h02);
      chk("reset select out", 8'h01, {7'h00, external_reset_select});
      chk("pf reset pin released", 8'h04, {5'h00, pf_pin_oe_n});
      rd(`DGPB_OFF_PF_LATCH, 1'b0, 8'h02, "pf reset pin read");
      // Strobes are ignored while the clock enable is low
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(`DGPB_OFF_P7_DIR, 8'hff);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rd(`DGPB_OFF_P7_DIR, 1'b0, 8'h0f, "frozen write ignored");
      // Reset in mid-run returns every pin to input
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("p7 oe_n mid-run reset", 8'hff, p7_pin_oe_n);
      rd(`DGPB_OFF_P7_DIR, 1'b0, 8'h00, "p7 direction mid-run reset");
      rd(`DGPB_OFF_PF_DIR, 1'b0, 8'h00, "pf direction mid-run reset");
      final_report();
   end
endmodule
